// File: logic/printer_ctrl_status_port.sv
// status and data holding port of the daisy-wheel printer controller
`timescale 1ns/1ns
`include "printer_ctrl_cfg.svh"
module printer_ctrl_status_port import printer_ctrl_pkg::*; #(
  parameter logic [`DEV_CODE_W-1:0] DEVICE_CODE = `DEVICE_CODE_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [`WORD_W-1:0] io_instr_in,
  input wire logic io_exec_in,
  input wire logic [`WORD_W-1:0] host_accumulator_in,
  output logic [`WORD_W-1:0] host_accumulator_out,
  output logic acc_load_out,
  output logic skip_out,
  output logic int_req_out,
  input wire logic prn_power_ok_in,
  input wire logic prn_check_in,
  input wire logic prn_char_ready_in,
  input wire logic prn_carriage_ready_in,
  input wire logic prn_paper_ready_in,
  input wire logic prn_restore_done_in,
  output logic [`WORD_W-1:0] prn_data_out,
  output logic print_strobe_out,
  output logic carriage_strobe_out,
  output logic paper_strobe_out,
  output logic restore_strobe_out,
  output logic left_paper_out,
  output logic ribbon_lift_out
);

  io_cmd_if cmd_bus ();

  logic [`READY_IN_W-1:0] prn_raw;
  logic [`READY_IN_W-1:0] prn_sync;

  // decoded command
  io_decode #(
    .DEVICE_CODE(DEVICE_CODE)
  ) u_decode (
    .io_instr_in(io_instr_in),
    .io_exec_in(io_exec_in),
    .cmd(cmd_bus.decoder)
  );

  // printer cable lines are asynchronous to the host clock
  always_comb begin
    prn_raw = '0;
    prn_raw[`SIN_POWER_OK] = prn_power_ok_in;
    prn_raw[`SIN_CHECK] = prn_check_in;
    prn_raw[`SIN_CHAR] = prn_char_ready_in;
    prn_raw[`SIN_CARR] = prn_carriage_ready_in;
    prn_raw[`SIN_PAPER] = prn_paper_ready_in;
    prn_raw[`SIN_RESTORE_DONE] = prn_restore_done_in;
  end

  // a read never sees a line mid-change
  sync2 #(
    .WIDTH(`READY_IN_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .d_in(prn_raw),
    .q_out(prn_sync)
  );

  // the printer-select line is grounded, so no input exists for it and nothing waits on it
  logic sel_any;
  assign sel_any = cmd_bus.sel;

  logic op_skip;
  logic op_rd_data;
  logic op_paper;
  logic op_carr;
  logic op_print;
  logic op_rd_stat;
  logic op_wr_stat;
  logic op_rest;

  // one strobe per operation code
  always_comb begin
    op_skip = sel_any && (cmd_bus.op == op_skip_done);
    op_rd_data = sel_any && (cmd_bus.op == data_read_op);
    op_paper = sel_any && (cmd_bus.op == op_move_paper);
    op_carr = sel_any && (cmd_bus.op == op_move_carriage);
    op_print = sel_any && (cmd_bus.op == op_print_char);
    op_rd_stat = sel_any && (cmd_bus.op == status_read_op);
    op_wr_stat = sel_any && (cmd_bus.op == op_write_status);
    op_rest = sel_any && (cmd_bus.op == op_restore);
  end

  // restore sequencer: starts out of reset so the carriage homes first
  restore_state_type restore_state_reg;
  restore_state_type restore_state_next;
  logic restore_strobe_reg;
  logic restore_strobe_next;
  logic restoring;
  logic restore_finished;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;

  always_comb begin
    restore_state_next = restore_state_reg;
    restore_strobe_next = 1'b0;
    restore_finished = 1'b0;
    settle_next = settle_reg;
    unique case (restore_state_reg)
      restore_idle: begin
        if (op_rest) begin
          restore_state_next = restore_issue;
        end
      end
      restore_issue: begin
        restore_strobe_next = 1'b1;
        settle_next = `RESTORE_SETTLE;
        restore_state_next = restore_wait;
      end
      restore_wait: begin
        // the synced done line still shows the old high for a few cycles after the strobe;
        // a printer slower than that to drop it would end the restore early
        if (settle_reg != 2'h0) begin
          settle_next = settle_reg - 2'h1;
        end else if (prn_sync[`SIN_RESTORE_DONE]) begin
          restore_state_next = restore_idle;
          restore_finished = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      restore_state_reg <= restore_issue;
      restore_strobe_reg <= `FLAG_RESET;
      settle_reg <= '0;
    end else begin
      restore_state_reg <= restore_state_next;
      restore_strobe_reg <= restore_strobe_next;
      settle_reg <= settle_next;
    end
  end

  assign restoring = (restore_state_reg != restore_idle);

  // status flags, software and hardware owned
  logic check_reg;
  logic check_next;
  logic done_reg;
  logic done_next;
  logic left_paper_reg;
  logic left_paper_next;
  logic lift_blk_reg;
  logic lift_blk_next;
  logic int_en_reg;
  logic int_en_next;
  logic [1:0] primed_reg;
  logic [1:0] primed_next;
  logic [2:0] ready_prev_reg;
  logic [2:0] ready_prev_next;
  logic [2:0] ready_now;
  logic ready_ok;
  logic done_set;
  logic done_clr;
  logic [`WORD_W-1:0] status_word;

  // ready bits are masked by the fault flag and by a restore in progress
  always_comb begin
    ready_ok = !check_reg && !restoring;
    ready_now = {prn_sync[`SIN_PAPER], prn_sync[`SIN_CARR], prn_sync[`SIN_CHAR]};
    status_word = '0;
    status_word[`STAT_PRN_READY] = prn_sync[`SIN_POWER_OK] && ready_ok;
    status_word[`STAT_CHAR_READY] = prn_sync[`SIN_CHAR] && ready_ok;
    status_word[`STAT_CARR_READY] = prn_sync[`SIN_CARR] && ready_ok;
    status_word[`STAT_PAPER_READY] = prn_sync[`SIN_PAPER] && ready_ok;
    status_word[`STAT_LEFT_PAPER] = left_paper_reg;
    status_word[`STAT_CHECK] = check_reg;
    status_word[`STAT_LIFT_BLK] = lift_blk_reg;
    status_word[`STAT_INT_EN] = int_en_reg;
  end

  // flag updates; a hardware set always wins over a clear in the same cycle
  always_comb begin
    ready_prev_next = ready_now;
    // the synchroniser reads power low until it has filled, which is no fault
    primed_next = {primed_reg[0], 1'b1};
    done_set = op_wr_stat || restore_finished || (|(ready_now & ~ready_prev_reg));
    done_clr = op_paper || op_carr || op_print || op_rd_stat || op_rest;
    done_next = done_set ? 1'b1 : (done_clr ? 1'b0 : done_reg);
    // a lasting fault keeps the flag set, since it wins over a write that would clear it
    if (primed_reg[1] && (!prn_sync[`SIN_POWER_OK] || prn_sync[`SIN_CHECK])) begin
      check_next = 1'b1;
    end else if (op_wr_stat) begin
      check_next = 1'b0;
    end else begin
      check_next = check_reg;
    end
    // only the writable bits take the accumulator; ready bits have no storage
    left_paper_next = op_wr_stat ? host_accumulator_in[`STAT_LEFT_PAPER] : left_paper_reg;
    lift_blk_next = op_wr_stat ? host_accumulator_in[`STAT_LIFT_BLK] : lift_blk_reg;
    int_en_next = op_wr_stat ? host_accumulator_in[`STAT_INT_EN] : int_en_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      check_reg <= `FLAG_RESET;
      done_reg <= `FLAG_RESET;
      left_paper_reg <= `FLAG_RESET;
      lift_blk_reg <= `FLAG_RESET;
      int_en_reg <= `FLAG_RESET;
      ready_prev_reg <= '0;
      primed_reg <= '0;
    end else begin
      check_reg <= check_next;
      done_reg <= done_next;
      left_paper_reg <= left_paper_next;
      lift_blk_reg <= lift_blk_next;
      int_en_reg <= int_en_next;
      ready_prev_reg <= ready_prev_next;
      primed_reg <= primed_next;
    end
  end

  // data holding word and motion strobes; commands into a busy printer are dropped
  logic [`WORD_W-1:0] data_hold_reg;
  logic [`WORD_W-1:0] data_hold_next;
  logic print_strobe_reg;
  logic print_strobe_next;
  logic carriage_strobe_reg;
  logic carriage_strobe_next;
  logic paper_strobe_reg;
  logic paper_strobe_next;

  always_comb begin
    print_strobe_next = op_print && status_word[`STAT_CHAR_READY];
    carriage_strobe_next = op_carr && status_word[`STAT_CARR_READY];
    paper_strobe_next = op_paper && status_word[`STAT_PAPER_READY];
    // the word is only captured; strobes come from the op, not from the load
    data_hold_next = print_strobe_next ? host_accumulator_in : data_hold_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_hold_reg <= `WORD_RESET;
      print_strobe_reg <= `FLAG_RESET;
      carriage_strobe_reg <= `FLAG_RESET;
      paper_strobe_reg <= `FLAG_RESET;
    end else begin
      data_hold_reg <= data_hold_next;
      print_strobe_reg <= print_strobe_next;
      carriage_strobe_reg <= carriage_strobe_next;
      paper_strobe_reg <= paper_strobe_next;
    end
  end

  // accumulator answer, skip and interrupt request, all registered
  logic [`WORD_W-1:0] acc_reg;
  logic [`WORD_W-1:0] acc_next;
  logic acc_load_reg;
  logic acc_load_next;
  logic skip_reg;
  logic skip_next;
  logic int_req_reg;
  logic int_req_next;

  always_comb begin
    acc_next = acc_reg;
    if (op_rd_stat) begin
      acc_next = status_word;
    end else if (op_rd_data) begin
      acc_next = data_hold_reg;
    end
    acc_load_next = op_rd_stat || op_rd_data;
    skip_next = op_skip && done_reg;
    int_req_next = done_next && int_en_next;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= `WORD_RESET;
      acc_load_reg <= `FLAG_RESET;
      skip_reg <= `FLAG_RESET;
      int_req_reg <= `FLAG_RESET;
    end else begin
      acc_reg <= acc_next;
      acc_load_reg <= acc_load_next;
      skip_reg <= skip_next;
      int_req_reg <= int_req_next;
    end
  end

  assign host_accumulator_out = acc_reg;
  assign acc_load_out = acc_load_reg;
  assign skip_out = skip_reg;
  assign int_req_out = int_req_reg;
  assign prn_data_out = data_hold_reg;
  assign print_strobe_out = print_strobe_reg;
  assign carriage_strobe_out = carriage_strobe_reg;
  assign paper_strobe_out = paper_strobe_reg;
  assign restore_strobe_out = restore_strobe_reg;
  assign left_paper_out = left_paper_reg;
  assign ribbon_lift_out = lift_blk_reg;

endmodule // printer_ctrl_status_port

// File: pkg/printer_ctrl_cfg.svh
// constants for the printer controller status port
`ifndef PRINTER_CTRL_CFG_SVH
`define PRINTER_CTRL_CFG_SVH

// word and field widths
`define WORD_W 12
`define DEV_CODE_W 6
`define OP_W 3
`define READY_IN_W 6

// instruction fields (host bit 0 is the msb, vector index 11)
`define INSTR_OPC_HI 11
`define INSTR_OPC_LO 9
`define INSTR_DEV_HI 8
`define INSTR_DEV_LO 3
`define INSTR_OP_HI 2
`define INSTR_OP_LO 0
`define IO_OPCODE 3'h6
`define DEVICE_CODE_DEFAULT 6'h28

// status word bit positions as vector indices (host bit n is index 11-n)
`define STAT_PRN_READY 11
`define STAT_CHAR_READY 10
`define STAT_CARR_READY 9
`define STAT_PAPER_READY 8
`define STAT_LEFT_PAPER 6
`define STAT_CHECK 5
`define STAT_LIFT_BLK 1
`define STAT_INT_EN 0

// synchronised printer input positions
`define SIN_POWER_OK 0
`define SIN_CHECK 1
`define SIN_CHAR 2
`define SIN_CARR 3
`define SIN_PAPER 4
`define SIN_RESTORE_DONE 5

// reset values
`define WORD_RESET 12'h000
`define FLAG_RESET 1'b0

// cycles the restore waits before trusting the synchronised done line
`define RESTORE_SETTLE 2'h3

`endif

// File: pkg/printer_ctrl_pkg.sv
// types shared by the printer controller modules
package printer_ctrl_pkg;

  // operation selected by instruction bits 9 to 11
  typedef enum logic [2:0] {
    op_skip_done,
    data_read_op,
    op_move_paper,
    op_move_carriage,
    op_print_char,
    status_read_op,
    op_write_status,
    op_restore
  } io_op_type;

  // restore sequencer
  typedef enum logic [1:0] {
    restore_idle,
    restore_issue,
    restore_wait
  } restore_state_type;

endpackage

// File: pkg/io_cmd_if.sv
// decoded io transfer instruction passed from decoder to controller
`timescale 1ns/1ns
interface io_cmd_if;
  import printer_ctrl_pkg::*;
  logic sel;
  io_op_type op;
  modport decoder (output sel, output op);
  modport ctrl (input sel, input op);
endinterface

// File: logic/sync2.sv
// two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule // sync2

// File: logic/io_decode.sv
// decodes an io transfer instruction addressed to this controller
`timescale 1ns/1ns
`include "printer_ctrl_cfg.svh"
module io_decode import printer_ctrl_pkg::*; #(
  parameter logic [`DEV_CODE_W-1:0] DEVICE_CODE = `DEVICE_CODE_DEFAULT
) (
  input wire logic [`WORD_W-1:0] io_instr_in,
  input wire logic io_exec_in,
  io_cmd_if.decoder cmd
);

  // opcode field must be the io opcode and the device field must match
  always_comb begin
    cmd.sel = io_exec_in
      && (io_instr_in[`INSTR_OPC_HI:`INSTR_OPC_LO] == `IO_OPCODE)
      && (io_instr_in[`INSTR_DEV_HI:`INSTR_DEV_LO] == DEVICE_CODE);
    cmd.op = io_op_type'(io_instr_in[`INSTR_OP_HI:`INSTR_OP_LO]);
  end

endmodule // io_decode

// File: test/printer_port_checker.sv
// concurrent checks on the printer controller status port
`timescale 1ns/1ns
module printer_port_checker (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [11:0] io_instr_in,
  input wire logic io_exec_in,
  input wire logic [11:0] host_accumulator_in,
  input wire logic [11:0] host_accumulator_out,
  input wire logic acc_load_out,
  input wire logic skip_out,
  input wire logic int_req_out,
  input wire logic [11:0] prn_data_out,
  input wire logic print_strobe_out,
  input wire logic carriage_strobe_out,
  input wire logic paper_strobe_out
);
  // one domain, so clock and reset are given once
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // instruction codes assume the default device code
  a_status_read_load: assert property (
    io_exec_in && io_instr_in == 12'hd45 |=> acc_load_out) else $error("no status load");
  a_data_read_word: assert property (
    io_exec_in && io_instr_in == 12'hd41 |=> acc_load_out
    && host_accumulator_out == $past(prn_data_out)) else $error("bad data read");
  a_foreign_quiet: assert property (
    io_exec_in && io_instr_in[8:3] != 6'h28 |=> !acc_load_out && !skip_out)
    else $error("foreign instruction taken");
  a_skip_cause: assert property (
    skip_out |-> $past(io_exec_in) && $past(io_instr_in) == 12'hd40) else $error("stray skip");
  a_data_hold_only: assert property (
    $changed(prn_data_out) |-> print_strobe_out) else $error("data word moved");
  a_print_load: assert property (
    print_strobe_out |-> prn_data_out == $past(host_accumulator_in)) else $error("bad print load");
  a_print_cause: assert property (
    print_strobe_out |-> $past(io_instr_in) == 12'hd44 && $past(io_exec_in))
    else $error("stray print strobe");
  a_carriage_cause: assert property (
    carriage_strobe_out |-> $past(io_instr_in) == 12'hd43 && $past(io_exec_in))
    else $error("stray carriage strobe");
  a_paper_cause: assert property (
    paper_strobe_out |-> $past(io_instr_in) == 12'hd42 && $past(io_exec_in))
    else $error("stray paper strobe");
  a_fault_mask: assert property (
    acc_load_out && $past(io_instr_in) == 12'hd45 && host_accumulator_out[5]
    |-> host_accumulator_out[11:8] == 4'h0) else $error("ready shown in fault");
  a_int_gate: assert property (
    acc_load_out && $past(io_instr_in) == 12'hd45 && !host_accumulator_out[0]
    |-> !int_req_out) else $error("request while disabled");
  // main scenarios reached
  cover property (print_strobe_out);
  cover property (skip_out && int_req_out);
  cover property (acc_load_out && host_accumulator_out[5]);
endmodule // printer_port_checker

bind printer_ctrl_status_port printer_port_checker u_chk (.mclk_in, .nrst_in, .io_instr_in,
  .io_exec_in, .host_accumulator_in, .host_accumulator_out, .acc_load_out, .skip_out,
  .int_req_out, .prn_data_out, .print_strobe_out, .carriage_strobe_out, .paper_strobe_out);

// File: test/printer_model.sv
// behavioural printer mechanism answering the controller strobes
`timescale 1ns/1ns
module printer_model #(
  parameter int BUSY = 20
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic print_strobe_in,
  input wire logic carriage_strobe_in,
  input wire logic paper_strobe_in,
  input wire logic restore_strobe_in,
  output logic char_ready_out,
  output logic carriage_ready_out,
  output logic paper_ready_out,
  output logic restore_done_out
);
  int n_ch, n_ca, n_pa, n_re;
  // each part stays busy after its strobe; power-up starts a restore
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      n_ch <= 0;
      n_ca <= 0;
      n_pa <= 0;
      n_re <= BUSY;
    end else begin
      n_ch <= print_strobe_in ? BUSY : (n_ch > 0 ? n_ch - 1 : 0);
      n_ca <= carriage_strobe_in ? BUSY : (n_ca > 0 ? n_ca - 1 : 0);
      n_pa <= paper_strobe_in ? BUSY : (n_pa > 0 ? n_pa - 1 : 0);
      n_re <= restore_strobe_in ? BUSY : (n_re > 0 ? n_re - 1 : 0);
    end
  end
  // nothing is ready while the carriage travels leftmost
  assign char_ready_out = (n_ch == 0) && (n_re == 0);
  assign carriage_ready_out = (n_ca == 0) && (n_re == 0);
  assign paper_ready_out = (n_pa == 0) && (n_re == 0);
  assign restore_done_out = (n_re == 0);
endmodule // printer_model

// File: test/tb.sv
// self-checking bench for the printer controller status port
`timescale 1ns/1ns
module tb;
  logic mclk_in = 0, nrst_in = 0, io_exec_in = 0, prn_power_ok_in = 1, prn_check_in = 0;
  logic [11:0] io_instr_in = 12'h000, host_accumulator_in = 12'h000;
  logic [11:0] host_accumulator_out, prn_data_out, rd, seen;
  logic acc_load_out, skip_out, int_req_out, print_strobe_out, carriage_strobe_out;
  logic paper_strobe_out, restore_strobe_out, left_paper_out, ribbon_lift_out;
  logic prn_char_ready_in, prn_carriage_ready_in, prn_paper_ready_in, prn_restore_done_in;
  int n_errors = 0, samples_checked = 0;
  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;
  printer_ctrl_status_port DUT (.mclk_in, .nrst_in, .io_instr_in, .io_exec_in,
    .host_accumulator_in, .host_accumulator_out, .acc_load_out, .skip_out, .int_req_out,
    .prn_power_ok_in, .prn_check_in, .prn_char_ready_in, .prn_carriage_ready_in,
    .prn_paper_ready_in, .prn_restore_done_in, .prn_data_out, .print_strobe_out,
    .carriage_strobe_out, .paper_strobe_out, .restore_strobe_out, .left_paper_out,
    .ribbon_lift_out);
  printer_model mech (.mclk_in, .nrst_in, .print_strobe_in(print_strobe_out),
    .carriage_strobe_in(carriage_strobe_out), .paper_strobe_in(paper_strobe_out),
    .restore_strobe_in(restore_strobe_out), .char_ready_out(prn_char_ready_in),
    .carriage_ready_out(prn_carriage_ready_in), .paper_ready_out(prn_paper_ready_in),
    .restore_done_out(prn_restore_done_in));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction; the answer stands only in the following cycle
  task automatic io_transfer_instruction(input logic [11:0] instr, input logic [11:0] acc);
    @(posedge mclk_in);
    #1;
    io_instr_in = instr;
    host_accumulator_in = acc;
    io_exec_in = 1;
    @(posedge mclk_in);
    #1;
    io_exec_in = 0;
    rd = host_accumulator_out;
    seen = {7'h00, acc_load_out, skip_out, print_strobe_out, carriage_strobe_out,
      paper_strobe_out};
  endtask
  // poll status until all four ready bits show, bounded
  task automatic wait_ready();
    int i;
    rd = 12'h000;
    for (i = 0; i < 100 && rd[11:8] !== 4'hf; i++) io_transfer_instruction(12'hd45, 12'h000);
    if (rd[11:8] !== 4'hf) begin
      check("ready wait", 12'h001, 12'h000);
      complete_run();
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    #1 nrst_in = 1;
    io_transfer_instruction(12'hd45, 12'h000);
    check("status in restore", 12'h000, rd);
    check("status load", 12'h010, seen);
    io_transfer_instruction(12'hd44, 12'h111);
    check("early print", 12'h000, seen);
    check("data word", 12'h000, prn_data_out);
    $display("test restore done");
    wait_ready();
    check("ready status", 12'hf00, rd);
    io_transfer_instruction(12'hd46, 12'h003);
    check("int request", 12'h001, {11'h000, int_req_out});
    check("ribbon lift", 12'h001, {11'h000, ribbon_lift_out});
    io_transfer_instruction(12'hd40, 12'h000);
    check("skip on done", 12'h008, seen);
    io_transfer_instruction(12'hd45, 12'h000);
    check("written status", 12'hf03, rd);
    check("int after read", 12'h000, {11'h000, int_req_out});
    $display("test status write done");
    io_transfer_instruction(12'hd44, 12'h0a5);
    check("print strobe", 12'h004, seen);
    check("data word", 12'h0a5, prn_data_out);
    repeat (5) @(posedge mclk_in);
    io_transfer_instruction(12'hd44, 12'h777);
    check("busy print", 12'h000, seen);
    io_transfer_instruction(12'hd41, 12'h000);
    check("data read", 12'h0a5, rd);
    wait_ready();
    io_transfer_instruction(12'hd43, 12'h000);
    check("carriage strobe", 12'h002, seen);
    wait_ready();
    io_transfer_instruction(12'hd42, 12'h000);
    check("paper strobe", 12'h001, seen);
    io_transfer_instruction(12'hd3d, 12'h000);
    check("other device", 12'h000, seen);
    io_transfer_instruction(12'hb45, 12'h000);
    check("other opcode", 12'h000, seen);
    $display("test motion done");
    // power fault first, then a mechanism check
    for (int k = 0; k < 2; k++) begin
      prn_power_ok_in = k[0];
      prn_check_in = k[0];
      repeat (4) @(posedge mclk_in);
      io_transfer_instruction(12'hd45, 12'h000);
      check("fault status", 12'h023, rd);
      prn_power_ok_in = 1;
      prn_check_in = 0;
      repeat (4) @(posedge mclk_in);
      io_transfer_instruction(12'hd45, 12'h000);
      check("fault kept", 12'h023, rd);
      io_transfer_instruction(12'hd46, 12'h003);
      wait_ready();
      check("fault cleared", 12'hf03, rd);
    end
    $display("test fault done");
    io_transfer_instruction(12'hd47, 12'h000);
    @(posedge mclk_in);
    #1 check("restore strobe", 12'h001, {11'h000, restore_strobe_out});
    wait_ready();
    check("after restore", 12'hf03, rd);
    $display("test restore op done");
    io_transfer_instruction(12'hd46, 12'h043);
    check("left paper", 12'h001, {11'h000, left_paper_out});
    io_transfer_instruction(12'hd45, 12'h000);
    check("left paper status", 12'hf43, rd);
    $display("test left paper done");
    // a second reset mid-run restarts the restore and must not leave a false fault
    nrst_in = 0;
    repeat (3) @(posedge mclk_in);
    #1 nrst_in = 1;
    io_transfer_instruction(12'hd45, 12'h000);
    check("status after reset", 12'h000, rd);
    wait_ready();
    check("ready after reset", 12'hf00, rd);
    $display("test second reset done");
    complete_run();
  end
endmodule // tb
